// File: hw/dif_pkg.sv
// Constants, types and register map of the drive input function logic
// How it works
// - While the terminal assigned to pulse count clear is on, the clear output holds the positioning count at zero.
// - The stored offset value is combined with the frequency setting only while the offset enable terminal is on.
// - While the offset enable terminal is off, the frequency command equals the unmodified setting.
// - A direction bit in the assignment register selects whether the offset is added or subtracted.
// - The offset acts on the incoming setting whatever frequency source is currently selected.
// - While the force terminal is on, both the frequency source and the run source report the control terminals.
// - When the force terminal is off again, the configured frequency and run sources are used once more.
// - A change of the force terminal while the motor runs raises a stop request and takes effect once it has stopped.
package dif_pkg;

    // ------------------------------------------------------------
    // Terminals and sources
    // ------------------------------------------------------------
    localparam int DIF_NUM_TERMS = 7;
    localparam logic [2:0] DIF_TERM_NONE = 3'h7;
    localparam logic [2:0] DIF_SRC_TERMINAL = 3'h1;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] DIF_OFS_ASSIGN = 8'h00;
    localparam logic [7:0] DIF_OFS_OFFSET = 8'h04;
    localparam logic [7:0] DIF_OFS_SOURCES = 8'h08;
    localparam logic [7:0] DIF_OFS_STATUS = 8'h0c;
    localparam logic [7:0] DIF_OFS_FREQ = 8'h10;
    localparam logic [7:0] DIF_ADDR_WORD_MASK = 8'hfc;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int DIF_ASG_PULSE_COUNT_CLEAR_INPUT_LSB = 0;
    localparam int DIF_ASG_OFFSET_LSB = 4;
    localparam int DIF_ASG_FORCE_LSB = 8;
    localparam int DIF_ASG_DIR_BIT = 12;
    localparam int DIF_SRC_FREQ_LSB = 0;
    localparam int DIF_SRC_RUN_LSB = 4;
    localparam int DIF_STS_PULSE_COUNT_CLEAR_INPUT_BIT = 0;
    localparam int DIF_STS_OFFSET_BIT = 1;
    localparam int DIF_STS_FORCE_BIT = 2;
    localparam int DIF_STS_APPLIED_BIT = 3;
    localparam int DIF_STS_STOP_BIT = 4;
    localparam int DIF_STS_EFREQ_LSB = 8;
    localparam int DIF_STS_ERUN_LSB = 12;
    localparam int DIF_STS_TERM_LSB = 16;

    // ------------------------------------------------------------
    // Reset values and bus answers
    // ------------------------------------------------------------
    localparam logic [12:0] DIF_RST_ASSIGN = 13'h0777;
    localparam logic [15:0] DIF_RST_OFFSET = 16'h0000;
    localparam logic [2:0] DIF_RST_SRC = 3'h0;
    localparam logic [1:0] DIF_RESP_OKAY = 2'h0;
    localparam logic [1:0] DIF_RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] run_src;
        logic [2:0] freq_src;
    } dif_sources_t;

    typedef enum logic [0:0] {
        DIF_ST_FOLLOW = 1'b0,
        DIF_ST_STOP = 1'b1
    } dif_state_t;

endpackage

// File: hw/dif_input_sync.sv
// Two-flop synchroniser for the intelligent input terminals
`timescale 1ns/1ps
module dif_input_sync import dif_pkg::*; #(
    parameter int W = DIF_NUM_TERMS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } dif_sync_state_t;

    dif_sync_state_t s;
    dif_sync_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.meta = async_in;
        next_s.stable = s.meta; // Only reader of the first stage
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign sync_out = s.stable;
endmodule

// File: hw/dif_freq_offset.sv
// Saturating add or subtract of the offset frequency
`timescale 1ns/1ps
module dif_freq_offset #(
    parameter int FREQ_W = 16
) (
    input wire logic [FREQ_W-1:0] base_freq,
    input wire logic [FREQ_W-1:0] offset_frequency_value,
    input wire logic offset_direction_select,
    input wire logic enable,
    output logic [FREQ_W-1:0] result
);
    logic [FREQ_W:0] sum;
    logic [FREQ_W:0] diff;

    // Wide sum and difference so that carry and borrow are visible
    assign sum = {1'b0, base_freq} + {1'b0, offset_frequency_value};
    assign diff = {1'b0, base_freq} - {1'b0, offset_frequency_value};

    // Select and clamp at the ends of the range
    always_comb begin
        result = base_freq;
        if (enable) begin
            if (offset_direction_select) begin
                result = diff[FREQ_W] ? '0 : diff[FREQ_W-1:0];
            end else begin
                result = sum[FREQ_W] ? '1 : sum[FREQ_W-1:0];
            end
        end
    end
endmodule

// File: hw/dif_top.sv
// Drive input functions: pulse clear, offset frequency, terminal source force
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module dif_top import dif_pkg::*; #(
    parameter int FREQ_W = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Input terminals and drive core
    input wire logic [DIF_NUM_TERMS-1:0] terminal_in,
    input wire logic [FREQ_W-1:0] base_freq_setting,
    input wire logic motor_running,
    output logic [FREQ_W-1:0] freq_command,
    output dif_sources_t effective_sources,
    output logic pulse_count_clear_input,
    output logic stop_request
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [12:0] assign_reg;
        logic [FREQ_W-1:0] offset_frequency_value;
        dif_sources_t settings;
        dif_state_t state;
        logic terminal_source_force;
        logic stop_request;
        logic pulse_clear;
        logic [FREQ_W-1:0] freq_command;
        dif_sources_t eff;
    } dif_top_state_t;

    dif_top_state_t s;
    dif_top_state_t next_s;

    logic [DIF_NUM_TERMS-1:0] term_level;
    logic pulse_count_clear_input_on;
    logic offset_on;
    logic force_on;
    logic [FREQ_W-1:0] offset_result;
    logic [31:0] status_word;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Level of the terminal that a function is assigned to
    function automatic logic pick_term(input logic [DIF_NUM_TERMS-1:0] lv, input logic [2:0] idx);
        pick_term = (idx < DIF_TERM_NONE) ? lv[idx] : 1'b0;
    endfunction

    // Merge written bytes into a word
    function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        apply_strb = r;
    endfunction

    // Known register word
    function automatic logic is_mapped(input logic [7:0] a);
        logic [7:0] w;
        w = a & DIF_ADDR_WORD_MASK;
        is_mapped = (w == DIF_OFS_ASSIGN) || (w == DIF_OFS_OFFSET) || (w == DIF_OFS_SOURCES) ||
                    (w == DIF_OFS_STATUS) || (w == DIF_OFS_FREQ);
    endfunction

    // ------------------------------------------------------------
    // Terminal inputs
    // ------------------------------------------------------------
    // synchronise terminals
    dif_input_sync #(
        .W(DIF_NUM_TERMS)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(terminal_in),
        .sync_out(term_level)
    );

    // Function levels from the assigned terminals
    assign pulse_count_clear_input_on = pick_term(term_level, s.assign_reg[DIF_ASG_PULSE_COUNT_CLEAR_INPUT_LSB +: 3]);
    assign offset_on = pick_term(term_level, s.assign_reg[DIF_ASG_OFFSET_LSB +: 3]);
    assign force_on = pick_term(term_level, s.assign_reg[DIF_ASG_FORCE_LSB +: 3]);

    dif_freq_offset #(
        .FREQ_W(FREQ_W)
    ) u_offset (
        .base_freq(base_freq_setting),
        .offset_frequency_value(s.offset_frequency_value),
        .offset_direction_select(s.assign_reg[DIF_ASG_DIR_BIT]),
        .enable(offset_on),
        .result(offset_result)
    );

    // Status word seen by software
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[DIF_STS_PULSE_COUNT_CLEAR_INPUT_BIT] = pulse_count_clear_input_on;
        status_word[DIF_STS_OFFSET_BIT] = offset_on;
        status_word[DIF_STS_FORCE_BIT] = force_on;
        status_word[DIF_STS_APPLIED_BIT] = s.terminal_source_force;
        status_word[DIF_STS_STOP_BIT] = s.stop_request;
        status_word[DIF_STS_EFREQ_LSB +: 3] = s.eff.freq_src;
        status_word[DIF_STS_ERUN_LSB +: 3] = s.eff.run_src;
        status_word[DIF_STS_TERM_LSB +: DIF_NUM_TERMS] = term_level;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [31:0] wr;
        logic [7:0] wa;
        logic [7:0] ra;
        wr = 32'h0000_0000;
        wa = s.aw_addr & DIF_ADDR_WORD_MASK;
        ra = s_axi_araddr & DIF_ADDR_WORD_MASK;
        next_s = s;

        // Write address and data taken in either order
        if (s_axi_awvalid && s.awready) begin
            next_s.aw_held = 1'b1;
            next_s.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wready) begin
            next_s.w_held = 1'b1;
            next_s.w_data = s_axi_wdata;
            next_s.w_strb = s_axi_wstrb;
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end

        // Register write once both halves are held
        if (s.aw_held && s.w_held && !s.bvalid) begin
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = is_mapped(s.aw_addr) ? DIF_RESP_OKAY : DIF_RESP_SLVERR;
            if (wa == DIF_OFS_ASSIGN) begin
                wr = apply_strb({19'h0, s.assign_reg}, s.w_data, s.w_strb);
                next_s.assign_reg = wr[12:0];
            end
            if (wa == DIF_OFS_OFFSET) begin
                wr = apply_strb(32'(s.offset_frequency_value), s.w_data, s.w_strb);
                next_s.offset_frequency_value = wr[FREQ_W-1:0];
            end
            if (wa == DIF_OFS_SOURCES) begin
                wr = apply_strb({25'h0, s.settings.run_src, 1'b0, s.settings.freq_src}, s.w_data, s.w_strb);
                next_s.settings.freq_src = wr[DIF_SRC_FREQ_LSB +: 3];
                next_s.settings.run_src = wr[DIF_SRC_RUN_LSB +: 3];
            end
        end
        next_s.awready = !next_s.aw_held && !next_s.bvalid;
        next_s.wready = !next_s.w_held && !next_s.bvalid;

        // Read channel, one read at a time
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
            next_s.arready = 1'b1;
        end
        if (s_axi_arvalid && s.arready) begin
            next_s.arready = 1'b0;
            next_s.rvalid = 1'b1;
            next_s.rresp = is_mapped(s_axi_araddr) ? DIF_RESP_OKAY : DIF_RESP_SLVERR;
            unique case (ra)
                DIF_OFS_ASSIGN: next_s.rdata = {19'h0, s.assign_reg};
                DIF_OFS_OFFSET: next_s.rdata = 32'(s.offset_frequency_value);
                DIF_OFS_SOURCES: next_s.rdata = {25'h0, s.settings.run_src, 1'b0, s.settings.freq_src};
                DIF_OFS_STATUS: next_s.rdata = status_word;
                DIF_OFS_FREQ: next_s.rdata = 32'(s.freq_command);
                default: next_s.rdata = 32'h0000_0000;
            endcase
        end

        next_s.pulse_clear = pulse_count_clear_input_on;
        next_s.freq_command = offset_result;

        // Force changeover, held off while the motor turns
        unique case (s.state)
            DIF_ST_FOLLOW: begin
                if (force_on != s.terminal_source_force) begin
                    if (motor_running) begin
                        next_s.state = DIF_ST_STOP;
                        next_s.stop_request = 1'b1;
                    end else begin
                        next_s.terminal_source_force = force_on;
                    end
                end
            end
            DIF_ST_STOP: begin
                if (!motor_running) begin
                    next_s.terminal_source_force = force_on;
                    next_s.stop_request = 1'b0;
                    next_s.state = DIF_ST_FOLLOW;
                end
            end
        endcase

        if (next_s.terminal_source_force) begin
            next_s.eff.freq_src = DIF_SRC_TERMINAL;
            next_s.eff.run_src = DIF_SRC_TERMINAL;
        end else begin
            next_s.eff = next_s.settings;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.awready <= 1'b1;
            s.wready <= 1'b1;
            s.arready <= 1'b1;
            s.assign_reg <= DIF_RST_ASSIGN;
            s.offset_frequency_value <= FREQ_W'(DIF_RST_OFFSET);
            s.settings.freq_src <= DIF_RST_SRC;
            s.settings.run_src <= DIF_RST_SRC;
            s.eff.freq_src <= DIF_RST_SRC;
            s.eff.run_src <= DIF_RST_SRC;
            s.state <= DIF_ST_FOLLOW;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all from the state register
    // ------------------------------------------------------------
    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign freq_command = s.freq_command;
    assign effective_sources = s.eff;
    assign pulse_count_clear_input = s.pulse_clear;
    assign stop_request = s.stop_request;

endmodule

// File: bench/dif_top_chk.sv
// Concurrent checks on the ports of the drive input function block
`timescale 1ns/1ps
module dif_top_chk import dif_pkg::*; #(
    parameter int FREQ_W = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic motor_running,
    input wire logic stop_request,
    input wire logic [FREQ_W-1:0] freq_command
);
    // ------------------------------------------------------------
    // Bus and stop properties
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_bvalid_held: // bus
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped or changed before bready");
    a_bvalid_done: // bus
        assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not retired after bready");
    a_rvalid_held: // bus
        assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped or changed before rready");
    a_read_busy: // bus
        assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while read data pending");
    a_write_busy: // bus
        assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write address accepted while response pending");
    a_stop_holds:
        assert property (stop_request && motor_running |=> stop_request)
        else $error("stop request dropped while motor still running");
    a_stop_idle:
        assert property (!motor_running |=> !stop_request)
        else $error("stop request present after motor stopped");
    a_stop_start:
        assert property ($rose(stop_request) |-> $past(motor_running))
        else $error("stop request raised while motor not running");
endmodule

bind dif_top dif_top_chk #(.FREQ_W(FREQ_W)) u_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .motor_running(motor_running),
    .stop_request(stop_request), .freq_command(freq_command));

// File: bench/dif_term_model.sv
// External switch bank driving the intelligent input terminals
`timescale 1ns/1ps
module dif_term_model import dif_pkg::*; (
    input wire logic aclk,
    output logic [DIF_NUM_TERMS-1:0] terminal_in
);
    // ------------------------------------------------------------
    // Switch levels, all open at power up
    // ------------------------------------------------------------
    initial terminal_in = '0;

    // Switch one terminal just after a clock edge
    task automatic set_term(input int idx, input logic lvl);
        @(posedge aclk);
        terminal_in[idx] <= lvl;
    endtask
endmodule

// File: bench/tb_top.sv
// Self-checking bench for the drive input function block
`timescale 1ns/1ps
module tb_top import dif_pkg::*;;
    // ------------------------------------------------------------
    // Signals and counters
    // ------------------------------------------------------------
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, stop_request, clr;
    logic [1:0] bresp, rresp;
    logic [6:0] terms;
    logic [15:0] base = 16'h0000, fcmd;
    logic running = 1'b0;
    dif_sources_t srcs;
    int failures = 0, num_checks = 0, cyc = 0;

    always #5 aclk = ~aclk;

    dif_term_model u_term (.aclk(aclk), .terminal_in(terms));

    dif_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .terminal_in(terms), .base_freq_setting(base), .motor_running(running),
        .freq_command(fcmd), .effective_sources(srcs), .pulse_count_clear_input(clr),
        .stop_request(stop_request));

    // ------------------------------------------------------------
    // Compare, bus and closing tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Write one word; address and data offered together, bready held until the answer
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                done = 1'b1;
                bready <= 1'b0;
                chk({30'h0, bresp}, {30'h0, er});
            end
        end
    endtask

    // Read one word and compare data and response
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                done = 1'b1;
                rready <= 1'b0;
                chk(rdata, ed);
                chk({30'h0, rresp}, {30'h0, er});
            end
        end
    endtask

    // Let outputs settle a number of edges after the last input change
    task automatic settle(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask

    // Cut a hang short
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            test_done();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset values, unmapped and read-only places
        rd(DIF_OFS_ASSIGN, 32'h0000_0777, DIF_RESP_OKAY);
        rd(DIF_OFS_OFFSET, 32'h0, DIF_RESP_OKAY);
        rd(DIF_OFS_SOURCES, 32'h0, DIF_RESP_OKAY);
        rd(8'h20, 32'h0, DIF_RESP_SLVERR);
        wr(8'h20, 32'h1, DIF_RESP_SLVERR);
        wr(DIF_OFS_FREQ, 32'h1234, DIF_RESP_OKAY);
        rd(DIF_OFS_FREQ, 32'h0, DIF_RESP_OKAY);
        // Clear on terminal 0, offset on 1, force on 2; sources freq 3, run 2
        wr(DIF_OFS_ASSIGN, 32'h0000_0210, DIF_RESP_OKAY);
        wr(DIF_OFS_OFFSET, 32'h0000_0100, DIF_RESP_OKAY);
        wr(DIF_OFS_SOURCES, 32'h0000_0023, DIF_RESP_OKAY);
        $display("registers done");
        // synchronised terminal level drives the clear
        u_term.set_term(0, 1'b1);
        settle(4);
        chk({31'h0, clr}, 32'h1);
        u_term.set_term(0, 1'b0);
        settle(4);
        chk({31'h0, clr}, 32'h0);
        $display("pulse clear done");
        @(posedge aclk) base <= 16'h1000;
        settle(3);
        chk({16'h0, fcmd}, 32'h1000);
        u_term.set_term(1, 1'b1);
        settle(4);
        chk({16'h0, fcmd}, 32'h1100);
        rd(DIF_OFS_FREQ, 32'h1100, DIF_RESP_OKAY);
        wr(DIF_OFS_ASSIGN, 32'h0000_1210, DIF_RESP_OKAY);
        settle(3);
        chk({16'h0, fcmd}, 32'h0f00);
        // offset applies whichever frequency source 0 to 6 is chosen
        for (int s = 0; s < 7; s++) begin
            wr(DIF_OFS_SOURCES, 32'h20 | s, DIF_RESP_OKAY);
            settle(3);
            chk({16'h0, fcmd}, 32'h0f00);
        end
        @(posedge aclk) base <= 16'h0080;
        settle(3);
        chk({16'h0, fcmd}, 32'h0000);
        wr(DIF_OFS_ASSIGN, 32'h0000_0210, DIF_RESP_OKAY);
        @(posedge aclk) base <= 16'hff80;
        settle(3);
        chk({16'h0, fcmd}, 32'hffff);
        u_term.set_term(1, 1'b0);
        settle(4);
        chk({16'h0, fcmd}, 32'hff80);
        // Byte strobes merge into the stored offset
        @(posedge aclk) wstrb <= 4'h1;
        wr(DIF_OFS_OFFSET, 32'h0000_3412, DIF_RESP_OKAY);
        rd(DIF_OFS_OFFSET, 32'h0000_0112, DIF_RESP_OKAY);
        @(posedge aclk) wstrb <= 4'hf;
        $display("offset done");
        wr(DIF_OFS_SOURCES, 32'h0000_0023, DIF_RESP_OKAY);
        u_term.set_term(2, 1'b1);
        settle(4);
        chk({26'h0, srcs}, {26'h0, DIF_SRC_TERMINAL, DIF_SRC_TERMINAL});
        u_term.set_term(2, 1'b0);
        settle(4);
        chk({26'h0, srcs}, {26'h0, 3'h2, 3'h3});
        // Force change while the motor runs waits for a stop
        @(posedge aclk) running <= 1'b1;
        u_term.set_term(2, 1'b1);
        settle(5);
        chk({31'h0, stop_request}, 32'h1);
        chk({26'h0, srcs}, {26'h0, 3'h2, 3'h3});
        @(posedge aclk) running <= 1'b0;
        settle(2);
        chk({31'h0, stop_request}, 32'h0);
        chk({26'h0, srcs}, {26'h0, DIF_SRC_TERMINAL, DIF_SRC_TERMINAL});
        // Status: force level and applied, both sources on terminals, terminal 2 high
        rd(DIF_OFS_STATUS, 32'h0004_110c, DIF_RESP_OKAY);
        $display("force done");
        test_done();
    end
endmodule
